/* File: shared/cmas_defines.svh */
// constants for the core memory address select block
`ifndef CMAS_DEFINES_SVH
`define CMAS_DEFINES_SVH
`define CMAS_ADDR_W 18
`define CMAS_DATA_W 16
`define CMAS_BYTE_W 8
`define CMAS_WA_W 13
`define CMAS_DEV_HI 17
`define CMAS_DEV_LO 14
`define CMAS_WA_HI 13
`define CMAS_WA_LO 1
`define CMAS_BYTE_BIT 0
`define CMAS_X_W 7
`define CMAS_Y_W 6
`define CMAS_X_LINES 128
`define CMAS_Y_LINES 64
`define CMAS_WORDS 8192
`define CMAS_BANK_W 4
`define CMAS_CLK_PS 5000
`define CMAS_PHASE_NS 100
`define CMAS_CNT_W 8
`endif

/* File: shared/cmas_pkg.sv */
// types for the core memory address select block
`default_nettype none
package cmas_pkg;
   typedef enum logic [1:0] {
      CMAS_IDLE  = 2'b00,
      CMAS_READ  = 2'b01,
      CMAS_WRITE = 2'b10,
      CMAS_DONE  = 2'b11
   } cmas_state_e;
   typedef enum logic [1:0] {
      CMAS_RD_RESTORE = 2'b00,
      CMAS_RD_PAUSE   = 2'b01,
      CMAS_WR_WORD    = 2'b10,
      CMAS_WR_BYTE    = 2'b11
   } cmas_mode_e;
endpackage : cmas_pkg
`default_nettype wire

/* File: logic/cmas_top.sv */
// core memory bank: device select, word decode, read/clear/write sequencing
`timescale 1ns/10ps
`default_nettype none
`include "cmas_defines.svh"
module cmas_top #(
   parameter int PHASE_CYC = (`CMAS_PHASE_NS * 1000 + `CMAS_CLK_PS - 1) / `CMAS_CLK_PS
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bank strap, positive logic
   input wire logic [`CMAS_BANK_W-1:0] bank_strap,
   // bus address and control, negative logic
   input wire logic [`CMAS_ADDR_W-1:0] bus_addr_l,
   input wire logic [1:0] bus_ctl_l,
   input wire logic bus_msyn_l,
   output logic bus_ssyn_l,
   // bus data, negative logic, three signals
   input wire logic [`CMAS_DATA_W-1:0] bus_data_l_i,
   output logic [`CMAS_DATA_W-1:0] bus_data_l_o,
   output logic bus_data_oe,
   // core drive and sense status
   output logic dev_sel,
   output logic [`CMAS_X_LINES-1:0] x_drv_en,
   output logic [`CMAS_Y_LINES-1:0] y_drv_en,
   output logic read_phase,
   output logic write_phase,
   output logic [`CMAS_DATA_W-1:0] inhibit,
   output logic [`CMAS_DATA_W-1:0] sense,
   output logic pause_flag
);

   localparam logic [`CMAS_CNT_W-1:0] PHASE_LAST = `CMAS_CNT_W'(PHASE_CYC - 1);

   function automatic logic [`CMAS_X_LINES-1:0] x_decode(input logic [`CMAS_X_W-1:0] idx);
      x_decode = '0;
      x_decode[idx] = 1'b1;
   endfunction : x_decode

   function automatic logic [`CMAS_Y_LINES-1:0] y_decode(input logic [`CMAS_Y_W-1:0] idx);
      y_decode = '0;
      y_decode[idx] = 1'b1;
   endfunction : y_decode

   // pin synchronisers, three stages
   logic [`CMAS_ADDR_W-1:0] addr_s1_r, addr_s2_r, addr_s3_r;
   logic [`CMAS_DATA_W-1:0] data_s1_r, data_s2_r, data_s3_r;
   logic [1:0] ctl_s1_r, ctl_s2_r, ctl_s3_r;
   logic msyn_s1_r, msyn_s2_r, msyn_s3_r;
   logic [`CMAS_BANK_W-1:0] strap_s1_r, strap_s2_r, strap_s3_r;
   logic msyn_act_r, msyn_act_nxt;

   always_comb begin
      msyn_act_nxt = msyn_act_r;
      if (msyn_s2_r == msyn_s3_r) begin
         msyn_act_nxt = ~msyn_s3_r;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_s1_r <= '1;
         addr_s2_r <= '1;
         addr_s3_r <= '1;
         data_s1_r <= '1;
         data_s2_r <= '1;
         data_s3_r <= '1;
         ctl_s1_r <= '1;
         ctl_s2_r <= '1;
         ctl_s3_r <= '1;
         msyn_s1_r <= 1'b1;
         msyn_s2_r <= 1'b1;
         msyn_s3_r <= 1'b1;
         strap_s1_r <= '0;
         strap_s2_r <= '0;
         strap_s3_r <= '0;
         msyn_act_r <= 1'b0;
      end else begin
         addr_s1_r <= bus_addr_l;
         addr_s2_r <= addr_s1_r;
         addr_s3_r <= addr_s2_r;
         data_s1_r <= bus_data_l_i;
         data_s2_r <= data_s1_r;
         data_s3_r <= data_s2_r;
         ctl_s1_r <= bus_ctl_l;
         ctl_s2_r <= ctl_s1_r;
         ctl_s3_r <= ctl_s2_r;
         msyn_s1_r <= bus_msyn_l;
         msyn_s2_r <= msyn_s1_r;
         msyn_s3_r <= msyn_s2_r;
         strap_s1_r <= bank_strap;
         strap_s2_r <= strap_s1_r;
         strap_s3_r <= strap_s2_r;
         msyn_act_r <= msyn_act_nxt;
      end
   end

   // address fields, positive logic
   logic [`CMAS_ADDR_W-1:0] addr_pos;
   logic dev_match;
   assign addr_pos = ~addr_s3_r;
   assign dev_match = (addr_pos[`CMAS_DEV_HI:`CMAS_DEV_LO] == strap_s3_r);

   // core array, one word per location, 16 planes wide
   logic [`CMAS_DATA_W-1:0] core_r [0:`CMAS_WORDS-1];

   // sequencer state
   cmas_pkg::cmas_state_e state_r, state_nxt;
   cmas_pkg::cmas_mode_e mode_r, mode_nxt;
   logic [`CMAS_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [`CMAS_WA_W-1:0] wa_r, wa_nxt;
   logic [`CMAS_WA_W-1:0] pause_wa_r, pause_wa_nxt;
   logic hi_r, hi_nxt;
   logic [`CMAS_DATA_W-1:0] wdata_r, wdata_nxt;
   logic [`CMAS_DATA_W-1:0] data_r, data_nxt;
   logic [`CMAS_DATA_W-1:0] sense_r, sense_nxt;
   logic [`CMAS_DATA_W-1:0] inh_r, inh_nxt;
   logic [`CMAS_X_LINES-1:0] x_en_r, x_en_nxt;
   logic [`CMAS_Y_LINES-1:0] y_en_r, y_en_nxt;
   logic pause_r, pause_nxt;
   logic ssyn_r, ssyn_nxt;
   logic oe_r, oe_nxt;
   logic sel_r, sel_nxt;
   logic core_clr, core_set;
   logic [`CMAS_DATA_W-1:0] core_word, write_word;
   logic phase_end;

   assign core_word = core_r[wa_r];
   assign phase_end = (cnt_r == PHASE_LAST);

   // word that the write phase stores
   function automatic logic [`CMAS_DATA_W-1:0] word_merge(input cmas_pkg::cmas_mode_e mode, input logic hi,
         input logic [`CMAS_DATA_W-1:0] wd, input logic [`CMAS_DATA_W-1:0] saved);
      word_merge = saved;
      unique case (mode)
         cmas_pkg::CMAS_RD_RESTORE: word_merge = saved;
         cmas_pkg::CMAS_RD_PAUSE: word_merge = saved;
         cmas_pkg::CMAS_WR_WORD: word_merge = wd;
         cmas_pkg::CMAS_WR_BYTE: begin
            if (hi) begin
               word_merge = {wd[`CMAS_DATA_W-1:`CMAS_BYTE_W], saved[`CMAS_BYTE_W-1:0]};
            end else begin
               word_merge = {saved[`CMAS_DATA_W-1:`CMAS_BYTE_W], wd[`CMAS_BYTE_W-1:0]};
            end
         end
      endcase
   endfunction : word_merge

   assign write_word = word_merge(mode_r, hi_r, wdata_r, data_r);

   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      cnt_nxt = cnt_r;
      wa_nxt = wa_r;
      pause_wa_nxt = pause_wa_r;
      hi_nxt = hi_r;
      wdata_nxt = wdata_r;
      data_nxt = data_r;
      sense_nxt = '0;
      inh_nxt = '0;
      x_en_nxt = x_en_r;
      y_en_nxt = y_en_r;
      pause_nxt = pause_r;
      ssyn_nxt = ssyn_r & msyn_act_r;
      oe_nxt = oe_r & msyn_act_r;
      sel_nxt = sel_r;
      core_clr = 1'b0;
      core_set = 1'b0;
      unique case (state_r)
         cmas_pkg::CMAS_IDLE: begin
            ssyn_nxt = 1'b0;
            oe_nxt = 1'b0;
            sel_nxt = 1'b0;
            x_en_nxt = '0;
            y_en_nxt = '0;
            if (msyn_act_r && dev_match) begin
               sel_nxt = 1'b1;
               mode_nxt = cmas_pkg::cmas_mode_e'(~ctl_s3_r);
               wa_nxt = addr_pos[`CMAS_WA_HI:`CMAS_WA_LO];
               hi_nxt = addr_pos[`CMAS_BYTE_BIT];
               wdata_nxt = ~data_s3_r;
               x_en_nxt = x_decode(addr_pos[`CMAS_WA_HI:`CMAS_WA_HI-`CMAS_X_W+1]);
               y_en_nxt = y_decode(addr_pos[`CMAS_WA_LO+`CMAS_Y_W-1:`CMAS_WA_LO]);
               cnt_nxt = '0;
               if (ctl_s3_r[1] == 1'b0 && pause_r && pause_wa_r == addr_pos[`CMAS_WA_HI:`CMAS_WA_LO]) begin
                  state_nxt = cmas_pkg::CMAS_WRITE;
               end else begin
                  state_nxt = cmas_pkg::CMAS_READ;
               end
               if (ctl_s3_r[1] == 1'b1) begin
                  pause_nxt = 1'b0;
               end
            end
         end
         cmas_pkg::CMAS_READ: begin
            cnt_nxt = cnt_r + `CMAS_CNT_W'(1);
            if (phase_end) begin
               cnt_nxt = '0;
               core_clr = 1'b1;
               sense_nxt = core_word;
               data_nxt = core_word;
               unique case (mode_r)
                  cmas_pkg::CMAS_RD_RESTORE: begin
                     ssyn_nxt = msyn_act_r;
                     oe_nxt = msyn_act_r;
                     state_nxt = cmas_pkg::CMAS_WRITE;
                  end
                  cmas_pkg::CMAS_RD_PAUSE: begin
                     ssyn_nxt = msyn_act_r;
                     oe_nxt = msyn_act_r;
                     pause_nxt = 1'b1;
                     pause_wa_nxt = wa_r;
                     state_nxt = cmas_pkg::CMAS_DONE;
                  end
                  cmas_pkg::CMAS_WR_WORD: state_nxt = cmas_pkg::CMAS_WRITE;
                  cmas_pkg::CMAS_WR_BYTE: state_nxt = cmas_pkg::CMAS_WRITE;
               endcase
            end
         end
         cmas_pkg::CMAS_WRITE: begin
            cnt_nxt = cnt_r + `CMAS_CNT_W'(1);
            inh_nxt = ~write_word;
            if (phase_end) begin
               cnt_nxt = '0;
               inh_nxt = '0;
               core_set = 1'b1;
               pause_nxt = 1'b0;
               if (mode_r != cmas_pkg::CMAS_RD_RESTORE) begin
                  ssyn_nxt = msyn_act_r;
               end
               state_nxt = cmas_pkg::CMAS_DONE;
            end
         end
         cmas_pkg::CMAS_DONE: begin
            if (!msyn_act_r) begin
               state_nxt = cmas_pkg::CMAS_IDLE;
               ssyn_nxt = 1'b0;
               oe_nxt = 1'b0;
               sel_nxt = 1'b0;
            end
         end
      endcase
      // inhibits stand from the first write cycle on
      if (state_nxt == cmas_pkg::CMAS_WRITE && state_r != cmas_pkg::CMAS_WRITE) begin
         inh_nxt = ~word_merge(mode_nxt, hi_nxt, wdata_nxt, data_nxt);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= cmas_pkg::CMAS_IDLE;
         mode_r <= cmas_pkg::CMAS_RD_RESTORE;
         cnt_r <= '0;
         wa_r <= '0;
         pause_wa_r <= '0;
         hi_r <= 1'b0;
         wdata_r <= '0;
         data_r <= '0;
         sense_r <= '0;
         inh_r <= '0;
         x_en_r <= '0;
         y_en_r <= '0;
         pause_r <= 1'b0;
         ssyn_r <= 1'b0;
         oe_r <= 1'b0;
         sel_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         cnt_r <= cnt_nxt;
         wa_r <= wa_nxt;
         pause_wa_r <= pause_wa_nxt;
         hi_r <= hi_nxt;
         wdata_r <= wdata_nxt;
         data_r <= data_nxt;
         sense_r <= sense_nxt;
         inh_r <= inh_nxt;
         x_en_r <= x_en_nxt;
         y_en_r <= y_en_nxt;
         pause_r <= pause_nxt;
         ssyn_r <= ssyn_nxt;
         oe_r <= oe_nxt;
         sel_r <= sel_nxt;
      end
   end

   // cores hold state without reset; write only sets uninhibited bits
   always_ff @(posedge clk) begin
      if (core_clr) begin
         core_r[wa_r] <= '0;
      end else if (core_set) begin
         core_r[wa_r] <= core_word | write_word;
      end
   end

   assign bus_ssyn_l = ~ssyn_r;
   assign bus_data_l_o = ~data_r;
   assign bus_data_oe = oe_r;
   assign dev_sel = sel_r;
   assign x_drv_en = x_en_r;
   assign y_drv_en = y_en_r;
   assign read_phase = (state_r == cmas_pkg::CMAS_READ);
   assign write_phase = (state_r == cmas_pkg::CMAS_WRITE);
   assign inhibit = inh_r;
   assign sense = sense_r;
   assign pause_flag = pause_r;

endmodule : cmas_top
`default_nettype wire

/* File: dv/cmas_props.sv */
// assertions on the ports of the core memory address select block
`timescale 1ns/10ps
`default_nettype none
module cmas_props #(
   parameter int PHASE_CYC = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bus side
   input wire logic [3:0] bank_strap,
   input wire logic [17:0] bus_addr_l,
   input wire logic [1:0] bus_ctl_l,
   input wire logic [15:0] bus_data_l_i,
   input wire logic [15:0] bus_data_l_o,
   input wire logic bus_data_oe,
   input wire logic bus_ssyn_l,
   // core side
   input wire logic dev_sel,
   input wire logic [127:0] x_drv_en,
   input wire logic [63:0] y_drv_en,
   input wire logic read_phase,
   input wire logic write_phase,
   input wire logic [15:0] inhibit,
   input wire logic [15:0] sense,
   input wire logic pause_flag
);
   logic [7:0] rcnt_r;
   logic [7:0] rcnt_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // length of the clearing read
   always_comb begin
      rcnt_nxt = read_phase ? rcnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rcnt_r <= 8'h00;
      end else begin
         rcnt_r <= rcnt_nxt;
      end
   end
   AST_INH_IDLE: assert property (!write_phase |-> inhibit == 16'h0000)
      else $error("inhibit outside write");
   AST_SEL: assert property ($rose(dev_sel) |-> ~bus_addr_l[17:14] == bank_strap)
      else $error("wrong bank selected");
   AST_DEC: assert property ($rose(dev_sel) |-> x_drv_en == (128'h1 << ~bus_addr_l[13:7])
      && y_drv_en == (64'h1 << ~bus_addr_l[6:1])) else $error("bad word decode");
   AST_CLEAR_FIRST: assert property ($rose(dev_sel) && !pause_flag |-> read_phase)
      else $error("no clearing read");
   AST_RD_LEN: assert property ($fell(read_phase) |-> rcnt_r == 8'(PHASE_CYC))
      else $error("read phase length");
   AST_RD_ANS: assert property ($fell(read_phase) && bus_ctl_l[1] |->
      !bus_ssyn_l && bus_data_oe && bus_data_l_o == ~sense) else $error("read answer");
   AST_RESTORE: assert property ($fell(read_phase) && bus_ctl_l == 2'b11 |->
      write_phase && inhibit == ~sense) else $error("restore write");
   AST_PAUSE: assert property ($fell(read_phase) && bus_ctl_l == 2'b10 |-> !write_phase)
      else $error("pause read restored");
   AST_WORD_INH: assert property ($fell(read_phase) && bus_ctl_l == 2'b01 |->
      inhibit == bus_data_l_i) else $error("word inhibit");
   AST_BYTE_INH: assert property ($fell(read_phase) && bus_ctl_l == 2'b00 |-> inhibit ==
      (bus_addr_l[0] ? {~sense[15:8], bus_data_l_i[7:0]} : {bus_data_l_i[15:8], ~sense[7:0]}))
      else $error("byte inhibit");
   AST_SENSE: assert property (sense != 16'h0000 |=> sense == 16'h0000)
      else $error("sense not a pulse");
endmodule : cmas_props
bind cmas_top cmas_props #(.PHASE_CYC(PHASE_CYC)) props_u (.clk, .resetn, .bank_strap, .bus_addr_l,
   .bus_ctl_l, .bus_data_l_i, .bus_data_l_o, .bus_data_oe, .bus_ssyn_l, .dev_sel, .x_drv_en,
   .y_drv_en, .read_phase, .write_phase, .inhibit, .sense, .pause_flag);
`default_nettype wire

/* File: dv/cmas_master.sv */
// bus master model driving the memory bank
`timescale 1ns/10ps
`default_nettype none
module cmas_master (
   // clock
   input wire logic clk,
   // bus side, negative logic
   output logic [17:0] bus_addr_l,
   output logic [1:0] bus_ctl_l,
   output logic bus_msyn_l,
   output logic [15:0] bus_data_l_i,
   input wire logic bus_ssyn_l,
   input wire logic [15:0] bus_data_l_o
);
   // lines idle high through the terminators
   initial begin
      bus_addr_l = '1;
      bus_ctl_l = '1;
      bus_msyn_l = 1'b1;
      bus_data_l_i = '1;
   end
   task automatic xfer(input logic [1:0] t, input logic [17:0] a, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 16'h0000;
      @(negedge clk);
      bus_addr_l = ~a;
      bus_ctl_l = ~t;
      bus_data_l_i = t[1] ? ~wd : 16'hffff;
      repeat (5) @(negedge clk);
      bus_msyn_l = 1'b0;
      n = 0;
      while (!ok && n < 60) begin
         @(posedge clk);
         n++;
         if (bus_ssyn_l === 1'b0) begin
            ok = 1'b1;
            rd = ~bus_data_l_o;
         end
      end
      @(negedge clk);
      bus_msyn_l = 1'b1;
      n = 0;
      while (bus_ssyn_l !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      @(negedge clk);
      bus_addr_l = '1;
      bus_ctl_l = '1;
      bus_data_l_i = '1;
      // let a restore write finish before the next request
      repeat (14) @(negedge clk);
   endtask : xfer
endmodule : cmas_master
`default_nettype wire

/* File: dv/cmas_top_tb.sv */
// self-checking bench for the core memory address select block
`timescale 1ns/10ps
`default_nettype none
module cmas_top_tb;
   logic clk, resetn, bus_msyn_l, bus_ssyn_l, bus_data_oe, dev_sel, read_phase, write_phase;
   logic pause_flag, ok;
   logic [3:0] bank_strap;
   logic [17:0] bus_addr_l;
   logic [1:0] bus_ctl_l;
   logic [15:0] bus_data_l_i, bus_data_l_o, inhibit, sense, rd, d;
   logic [127:0] x_drv_en;
   logic [63:0] y_drv_en;
   logic [15:0] mem [0:8191];
   logic [12:0] wa;
   int errors, compares, cyc;
   integer seed;
   cmas_top #(.PHASE_CYC(4)) dut_u (.clk, .resetn, .bank_strap, .bus_addr_l, .bus_ctl_l,
      .bus_msyn_l, .bus_ssyn_l, .bus_data_l_i, .bus_data_l_o, .bus_data_oe, .dev_sel,
      .x_drv_en, .y_drv_en, .read_phase, .write_phase, .inhibit, .sense, .pause_flag);
   cmas_master mst_u (.clk, .bus_addr_l, .bus_ctl_l, .bus_msyn_l, .bus_data_l_i,
      .bus_ssyn_l, .bus_data_l_o);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      if (errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic hi);
      return hi ? {nw[15:8], old[7:0]} : {old[15:8], nw[7:0]};
   endfunction : merge
   // one transfer to this bank, tracking expected core contents
   task automatic op(input logic [1:0] t, input logic [12:0] w, input logic a0, input logic [15:0] wd);
      mst_u.xfer(t, {bank_strap, w, a0}, wd, rd, ok);
      chk({15'h0000, ok}, 16'h0001);
      if (!t[1]) chk(rd, mem[w]);
      if (t == 2'h2) mem[w] = wd;
      if (t == 2'h3) mem[w] = merge(mem[w], wd, a0);
   endtask : op
   initial begin
      seed = 32'haea8;
      resetn = 1'b0;
      bank_strap = 4'($random(seed));
      repeat (5) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      // first and last word of the bank, extreme patterns
      op(2'h2, 13'h0000, 1'b0, 16'h0000);
      op(2'h2, 13'h1fff, 1'b0, 16'hffff);
      op(2'h0, 13'h0000, 1'b0, 16'h0000);
      op(2'h0, 13'h1fff, 1'b0, 16'h0000);
      for (int i = 0; i < 24; i++) begin
         wa = 13'($random(seed));
         d = 16'($random(seed));
         op(2'h2, wa, 1'b0, d);
         op(2'h3, wa, i[0], ~d);
         op(2'h0, wa, 1'b0, 16'h0000);
         op(2'h0, wa, 1'b0, 16'h0000);
         op(2'h1, wa, 1'b0, 16'h0000);
         chk({15'h0000, pause_flag}, 16'h0001);
         op({1'b1, i[1]}, wa, i[2], d ^ 16'h5a5a);
         chk({15'h0000, pause_flag}, 16'h0000);
         op(2'h0, wa, 1'b0, 16'h0000);
      end
      // another bank's address is ignored
      mst_u.xfer(2'h0, {~bank_strap, wa, 1'b0}, 16'h0000, rd, ok);
      chk({15'h0000, ok}, 16'h0000);
      test_done();
   end
endmodule : cmas_top_tb
`default_nettype wire
